// [urhd_pkg.sv]
// Package: register map and field layout of the root hub descriptor bank
package urhd_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] URHD_OFF_DESC_FIRST = 8'h00;
  localparam logic [7:0] URHD_OFF_STATUS     = 8'h04;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int URHD_SETTLE_HI   = 31;
  localparam int URHD_SETTLE_LO   = 24;
  localparam int URHD_NO_OC_BIT   = 12;
  localparam int URHD_OC_MODE_BIT = 11;
  localparam int URHD_COMPND_BIT  = 10;
  localparam int URHD_NO_SW_BIT   = 9;
  localparam int URHD_SW_MODE_BIT = 8;
  localparam int URHD_PORTS_HI    = 7;
  localparam int URHD_PORTS_LO    = 0;

  // ****************************************
  // Reset and fixed values
  // ****************************************
  localparam logic [7:0] URHD_SETTLE_RST  = 8'h00;
  localparam logic       URHD_NO_OC_RST   = 1'b1;
  localparam logic       URHD_OC_MODE_RST = 1'b0;
  localparam logic       URHD_COMPND_VAL  = 1'b0;
  localparam logic       URHD_NO_SW_RST   = 1'b1;
  localparam logic       URHD_SW_MODE_RST = 1'b0;
  localparam logic [7:0] URHD_PORTS_VAL   = 8'h03;

  // ****************************************
  // Timing
  // ****************************************
  localparam int URHD_SETTLE_UNIT_MS = 2;

  // Bus slave states
  typedef enum logic [1:0]
  {
    URHD_IDLE = 2'b01,
    URHD_ACK  = 2'b10
  } urhd_state_e;

endpackage

// [urhd_desc_reg.sv]
// Storage of the writable descriptor fields with byte-lane writes
`timescale 1ns/1ps
module urhd_desc_reg
  import urhd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_sel,
  input  wire logic [31:0] wr_data,
  // Stored fields
  output logic [7:0]  settle_q,
  output logic        no_oc_q,
  output logic        oc_mode_q,
  output logic        no_sw_q,
  output logic        sw_mode_q
);

  wire lane1_wr = wr_en && wr_sel[1];
  wire lane3_wr = wr_en && wr_sel[3];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settle_q  <= URHD_SETTLE_RST;
      no_oc_q   <= URHD_NO_OC_RST;
      oc_mode_q <= URHD_OC_MODE_RST;
      no_sw_q   <= URHD_NO_SW_RST;
      sw_mode_q <= URHD_SW_MODE_RST;
    end
    else
    begin
      if (lane3_wr)
        settle_q <= wr_data[URHD_SETTLE_HI:URHD_SETTLE_LO];
      if (lane1_wr)
      begin
        no_oc_q   <= wr_data[URHD_NO_OC_BIT];
        oc_mode_q <= wr_data[URHD_OC_MODE_BIT];
        no_sw_q   <= wr_data[URHD_NO_SW_BIT];
        sw_mode_q <= wr_data[URHD_SW_MODE_BIT];
      end
    end
  end

endmodule

// [urhd_top.sv]
// Root hub first descriptor register bank on classic Wishbone
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - No-overcurrent flag bit 12 resets to one
// - Overcurrent mode bit 11 resets zero, inert
// - Compound device bit 10 always zero
// - No-switching bit 9 resets to one
// - Software may write the descriptor register
// - Switching mode bit 8 resets zero
// - Port count always reports three
// - Settle delay byte stored, never used
module urhd_top
  import urhd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o,
  output logic        wb_err_o,
  // Capability levels
  output logic        no_overcurrent_guard,
  output logic        no_supply_switching
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ****************************************
  // Decode helpers
  // ****************************************
  // One register selected by a byte address
  function automatic logic urhd_adr_hit
  (
    input logic [7:0] adr,
    input logic [7:0] off
  );
    urhd_adr_hit = (adr == off);
  endfunction

  // Descriptor fields packed at their bit positions
  function automatic logic [31:0] urhd_pack_desc
  (
    input logic [7:0] settle,
    input logic       no_oc,
    input logic       oc_mode,
    input logic       no_sw,
    input logic       sw_mode
  );
    logic [31:0] word;
    word                                = 32'h0000_0000;
    word[URHD_SETTLE_HI:URHD_SETTLE_LO] = settle;
    word[URHD_NO_OC_BIT]                = no_oc;
    word[URHD_OC_MODE_BIT]              = oc_mode;
    word[URHD_COMPND_BIT]               = URHD_COMPND_VAL;
    word[URHD_NO_SW_BIT]                = no_sw;
    word[URHD_SW_MODE_BIT]              = sw_mode;
    word[URHD_PORTS_HI:URHD_PORTS_LO]   = URHD_PORTS_VAL;
    urhd_pack_desc = word;
  endfunction

  // Status view: capability levels in the low bits
  function automatic logic [31:0] urhd_pack_stat
  (
    input logic no_oc,
    input logic no_sw
  );
    urhd_pack_stat = {30'h0000_0000, no_sw, no_oc};
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  urhd_state_e state_q;
  urhd_state_e state_d;

  logic [7:0]  settle_q;
  logic        no_oc_q;
  logic        oc_mode_q;
  logic        no_sw_q;
  logic        sw_mode_q;

  wire         req      = wb_cyc_i && wb_stb_i && (state_q == URHD_IDLE);
  wire         hit_desc = urhd_adr_hit(wb_adr_i, URHD_OFF_DESC_FIRST);
  wire         hit_stat = urhd_adr_hit(wb_adr_i, URHD_OFF_STATUS);
  wire         hit      = hit_desc || hit_stat;
  wire         desc_wr  = req && wb_we_i && hit_desc;
  wire         rd_req   = req && !wb_we_i;

  // ****************************************
  // Read path
  // ****************************************
  // whole word assembled
  wire  [31:0] desc_word = urhd_pack_desc(settle_q, no_oc_q, oc_mode_q,
                                          no_sw_q, sw_mode_q);
  wire  [31:0] stat_word = urhd_pack_stat(no_oc_q, no_sw_q);
  wire  [31:0] rd_word   = hit_desc ? desc_word :
                           hit_stat ? stat_word : 32'h0000_0000;

  // Answer and read data, zero outside a taken request
  wire  [31:0] dat_d     = rd_req ? rd_word : 32'h0000_0000;
  wire         ack_d     = req && hit;
  wire         err_d     = req && !hit;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      URHD_IDLE: if (wb_cyc_i && wb_stb_i) state_d = URHD_ACK;
      URHD_ACK:  state_d = URHD_IDLE;
      default:   state_d = URHD_IDLE;
    endcase
  end

  // ****************************************
  // Writable fields
  // ****************************************
  // software writes taken
  urhd_desc_reg u_desc
  (
    .clk       (clk),
    .rst_n     (rst_n_q),
    .wr_en     (desc_wr),
    .wr_sel    (wb_sel_i),
    .wr_data   (wb_dat_i),
    .settle_q  (settle_q),
    .no_oc_q   (no_oc_q),
    .oc_mode_q (oc_mode_q),
    .no_sw_q   (no_sw_q),
    .sw_mode_q (sw_mode_q)
  );

  // ****************************************
  // Bus state
  // ****************************************
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      state_q <= URHD_IDLE;
    else
      state_q <= state_d;
  end

  // ****************************************
  // Answer registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= ack_d;
      wb_err_o <= err_d;
    end
  end

  // ****************************************
  // Read data register
  // ****************************************
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      wb_dat_o <= 32'h0000_0000;
    else
      wb_dat_o <= dat_d;
  end

  // ****************************************
  // Capability levels
  // ****************************************
  // levels follow stored flags
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      no_overcurrent_guard <= URHD_NO_OC_RST;
      no_supply_switching  <= URHD_NO_SW_RST;
    end
    else
    begin
      no_overcurrent_guard <= no_oc_q;
      no_supply_switching  <= no_sw_q;
    end
  end

endmodule

// [urhd_props.sv]
// Checker: bus and field properties of the descriptor bank
`timescale 1ns/1ps
module urhd_props
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // Capability levels
  input wire logic        no_overcurrent_guard,
  input wire logic        no_supply_switching
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_rd0;
    s_req ##0 !wb_we_i && wb_adr_i == 8'h00;
  endsequence
  sequence s_wr0;
    s_req ##0 wb_we_i && wb_adr_i == 8'h00;
  endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_err_pulse: assert property (wb_err_o |=> !wb_err_o)
    else $error("error held longer than one cycle");
  a_fixed_fields: assert property (s_rd0 |=> wb_ack_o &&
    wb_dat_o[10] == 1'b0 && wb_dat_o[7:0] == 8'h03)
    else $error("fixed descriptor fields wrong");
  a_read_flags: assert property (s_rd0 |=>
    wb_dat_o[12] == no_overcurrent_guard && wb_dat_o[9] == no_supply_switching)
    else $error("read flags differ from levels");
  a_write_lands: assert property (s_wr0 ##0 wb_sel_i[1] |-> ##2
    no_overcurrent_guard == $past(wb_dat_i[12], 2) &&
    no_supply_switching == $past(wb_dat_i[9], 2))
    else $error("written flags not applied");
  a_lane_guard: assert property (s_wr0 ##0 !wb_sel_i[1] |-> ##2
    $stable(no_overcurrent_guard) && $stable(no_supply_switching))
    else $error("flags changed without lane");
  a_unmapped_err: assert property (s_req ##0 wb_adr_i > 8'h07 |=>
    wb_err_o && !wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_status_map: assert property (
    s_req ##0 !wb_we_i && wb_adr_i == 8'h04 |=>
    wb_dat_o[1:0] == {no_supply_switching, no_overcurrent_guard})
    else $error("status read wrong");
  a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
endmodule
bind urhd_top urhd_props i_props (.clk(clk), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .no_overcurrent_guard(no_overcurrent_guard),
  .no_supply_switching(no_supply_switching));

// [usb_root_hub_descriptor_low_tb_top.sv]
// Testbench: register access scenarios for the descriptor bank
`timescale 1ns/1ps
module usb_root_hub_descriptor_low_tb_top;
  logic        clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, dat_o, rd;
  logic        ack, err, no_oc, no_sw, e;
  int          mismatches = 0, total_checks = 0;
  always #10 clk = ~clk;
  urhd_top i_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
    .no_overcurrent_guard(no_oc), .no_supply_switching(no_sw));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    rd = dat_o;
    e = err;
    {cyc, stb} <= 2'b00;
    if (n >= 50)
    begin
      mismatches++;
      stop_test();
    end
  endtask
  task automatic t_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'({no_sw, no_oc}), 32'h0000_0003);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    wb(1'b0, 8'h00, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_1203);
  endtask
  task automatic t_write_lanes;
    wb(1'b1, 8'h00, 4'hf, 32'hffff_ffff);
    wb(1'b0, 8'h00, 4'hf, 32'h0000_0000);
    chk(rd, 32'hff00_1b03);
    wb(1'b1, 8'h00, 4'hd, 32'h0000_0000);
    wb(1'b0, 8'h00, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_1b03);
    wb(1'b1, 8'h00, 4'h2, 32'h0000_0000);
    wb(1'b0, 8'h04, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'({no_sw, no_oc}), 32'h0000_0000);
  endtask
  task automatic t_refused;
    wb(1'b1, 8'h08, 4'hf, 32'hffff_ffff);
    chk(32'(e), 32'h0000_0001);
    wb(1'b0, 8'h08, 4'hf, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    wb(1'b1, 8'h04, 4'hf, 32'hffff_ffff);
    wb(1'b0, 8'h00, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #100us;
    mismatches++;
    stop_test();
  end
  initial
  begin
    t_reset();
    t_write_lanes();
    t_refused();
    t_reset();
    stop_test();
  end
endmodule
